// [rtl/contactless_cmd_irq_ctrl.sv]
// Purpose: AHB-Lite slave holding the command, enable, status and clear registers.
// Assumes: Event inputs are one-cycle pulses synchronous to hclk.
// Notes: Zero wait states; every answer is OKAY; unmapped words read zero.
//
// Our own choice: the AHB-Lite interface to the registers.
`include "irq_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module contactless_cmd_irq_ctrl #(
	parameter int DECODE_BITS = 4
) (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire logic [`FLAG_COUNT-1:0]  ext_event,
	output logic                         tx_active,
	output logic                         rx_enable,
	output logic                         prbs_data,
	output logic                         irq
);
	import irq_ctrl_pkg::*;

	// Four index bits are the least that reach the clear register
	if (DECODE_BITS < 4 || DECODE_BITS > 30) begin : g_bad_decode
		$error("DECODE_BITS out of range");
	end

	// Address bits above the index that must be zero for a mapped word
	localparam logic [25:0] HI_MASK = (26'h1 << (DECODE_BITS - 4)) - 26'h1;

	irq_ctrl_pkg::core_t  cur;
	irq_ctrl_pkg::core_t  next_cur;
	logic                 take;
	logic                 wr_ctrl;
	logic                 wr_clear;
	logic [2:0]           new_code;
	logic [`FLAG_COUNT-1:0] src_event;
	logic [`FLAG_COUNT-1:0] clear_mask;
	logic [`FLAG_COUNT-1:0] next_status;
	logic [`FLAG_COUNT-1:0] eff_enable;
	logic                 unmapped;

	// Address phase is taken only for an active transfer while the bus is ready
	assign take = hsel && hready && htrans[1];
	assign unmapped = |(haddr[31:6] & HI_MASK);
	assign wr_ctrl = cur.wr_pend && (cur.wr_idx == `IDX_CONTROL);
	assign wr_clear = cur.wr_pend && (cur.wr_idx == `IDX_CLEAR);
	assign new_code = hwdata[`CMD_MSB:`CMD_LSB];
	assign clear_mask = wr_clear ? hwdata[`FLAG_COUNT-1:0] : '0;

	// Card detect, program fail and general error always reach the pin
	assign eff_enable = {`EN_FIXED, cur.enable};

	// Pin events; state machine events are added later to avoid a loop through next_cur
	assign src_event = ext_event;

	// Sticky flags; an event in the cycle of its clear still sets the flag
	// Each input position lands on the same status bit
	genvar gi;
	generate
		for (gi = 0; gi < `FLAG_COUNT; gi++) begin : g_flag
			assign next_status[gi] = src_event[gi] ||
				(cur.status[gi] && !clear_mask[gi]);
		end
	endgenerate

	// Next state of registers, command machine and sequence generator
	always_comb begin
		next_cur = cur;
		next_cur.wr_pend = 1'b0;
		// Register write commits during its data phase
		if (wr_ctrl) begin
			next_cur.start_send = hwdata[`START_SEND_BIT];
			next_cur.seq_sel = hwdata[`SEQ_SEL_BIT];
			next_cur.initiator = hwdata[`INITIATOR_BIT];
			unique case (new_code)
				`CMD_HALT: begin
					next_cur.command = new_code;
					next_cur.fsm = st_idle;
				end
				`CMD_TRANSCEIVE: begin
					next_cur.command = new_code;
					next_cur.fsm = hwdata[`INITIATOR_BIT] ? st_send : st_listen;
				end
				`CMD_ECHO: begin
					next_cur.command = new_code;
					next_cur.fsm = st_echo;
				end
				`CMD_RANDOM: begin
					next_cur.command = new_code;
					next_cur.fsm = st_random;
					next_cur.lfsr = `LFSR_SEED;
				end
				// Retain and unassigned codes leave the command as it is
				default: begin
					next_cur.command = cur.command;
				end
			endcase
		end else begin
			// Transceive only moves from sending to listening, never out
			if (cur.fsm == st_send && ext_event[`BIT_TX_END]) begin
				next_cur.fsm = st_listen;
			end
		end
		if (cur.wr_pend && cur.wr_idx == `IDX_ENABLE) begin
			next_cur.enable = hwdata[`EN_RW_COUNT-1:0];
		end
		next_cur.status = next_status;
		// Internal events from the state register; set wins over a clear
		if (next_cur.fsm != cur.fsm) begin
			next_cur.status[`BIT_STATE_CHG] = 1'b1;
		end
		if (next_cur.fsm == st_idle && cur.fsm != st_idle) begin
			next_cur.status[`BIT_IDLE] = 1'b1;
		end
		// Random sequence steps every clock without a control write while transmitting endlessly
		if (cur.fsm == st_random && !wr_ctrl) begin
			if (cur.seq_sel) begin
				next_cur.lfsr = {cur.lfsr[13:0], cur.lfsr[14] ^ cur.lfsr[13]};
			end else begin
				next_cur.lfsr = {6'h00, cur.lfsr[7:0], cur.lfsr[8] ^ cur.lfsr[4]};
			end
		end
		// Address phase: latch index and prepare read data from the updated copy
		if (take) begin
			next_cur.wr_pend = hwrite && !unmapped;
			next_cur.wr_idx = haddr[5:2];
			next_cur.rdata = 32'h0000_0000;
			if (!hwrite && !unmapped) begin
				unique case (haddr[5:2])
					`IDX_CONTROL: begin
						next_cur.rdata[`CMD_MSB:`CMD_LSB] = next_cur.command;
						next_cur.rdata[`START_SEND_BIT] = next_cur.start_send;
						next_cur.rdata[`SEQ_SEL_BIT] = next_cur.seq_sel;
						next_cur.rdata[`INITIATOR_BIT] = next_cur.initiator;
					end
					`IDX_ENABLE: begin
						next_cur.rdata[`FLAG_COUNT-1:0] = {`EN_FIXED, next_cur.enable};
					end
					`IDX_STATUS: begin
						next_cur.rdata[`FLAG_COUNT-1:0] = next_cur.status;
					end
					default: begin
						next_cur.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// Single register stage for all state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur.wr_pend <= 1'b0;
			cur.wr_idx <= 4'h0;
			cur.rdata <= 32'h0000_0000;
			cur.command <= `CMD_RESET;
			cur.start_send <= 1'b0;
			cur.seq_sel <= 1'b0;
			cur.initiator <= 1'b0;
			cur.enable <= '0;
			cur.status <= '0;
			cur.fsm <= st_idle;
			cur.lfsr <= `LFSR_SEED;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs; hsize is ignored because only whole words are served
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur.rdata;
	assign tx_active = (cur.fsm == st_send) || (cur.fsm == st_echo) || (cur.fsm == st_random);
	assign rx_enable = (cur.fsm == st_listen) || (cur.fsm == st_echo);
	assign prbs_data = (cur.fsm == st_random) && cur.lfsr[0];
	assign irq = |(cur.status & eff_enable);

	// Checks
	a_start_transceive: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_TRANSCEIVE |=> (cur.command == `CMD_TRANSCEIVE) &&
		(tx_active || rx_enable))
		else $error("transceive not started");

	a_initiator_branch: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_TRANSCEIVE |=>
		(tx_active == $past(hwdata[`INITIATOR_BIT])) && (rx_enable != tx_active))
		else $error("transceive branch wrong");

	a_transceive_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(cur.fsm == st_send || cur.fsm == st_listen) && !wr_ctrl |=>
		(cur.fsm == st_send || cur.fsm == st_listen))
		else $error("transceive left by itself");

	a_keep_command: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_RETAIN |=> $stable(cur.command) && $stable(cur.fsm))
		else $error("retain code changed command");

	a_echo_both: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_ECHO |=> tx_active && rx_enable)
		else $error("echo mode not both");

	a_random_runs: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_random && !wr_ctrl |=> cur.fsm == st_random && tx_active)
		else $error("random transmission stopped");

	a_halt_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_HALT |=> !tx_active && !rx_enable ##0
		cur.status[`BIT_IDLE] || $past(cur.fsm) == st_idle)
		else $error("halt did not idle");

	a_short_sequence: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_random && !cur.seq_sel && !wr_ctrl |=> cur.lfsr[14:9] == 6'h00)
		else $error("short sequence too wide");

	a_fixed_enables: assert property (@(posedge hclk) disable iff (!hresetn)
		|cur.status[19:17] |-> irq)
		else $error("fixed enable not effective");

	a_enable_gates: assert property (@(posedge hclk) disable iff (!hresetn)
		!(|cur.enable) && !(|cur.status[19:17]) |-> !irq)
		else $error("disabled flag drove pin");

	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == |(cur.status & {`EN_FIXED, cur.enable}))
		else $error("interrupt level wrong");

	a_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_event[11] && ext_event[19] |=> cur.status[11] && cur.status[19])
		else $error("event did not set flag");

	a_clear_works: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_clear && hwdata[16] && !ext_event[16] |=> !cur.status[16])
		else $error("clear ignored");

	a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.status[14] && !(wr_clear && hwdata[14]) |=> cur.status[14])
		else $error("flag dropped without clear");

	// Command machine holds its mode until a new command is written
	a_transceive_code: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_send || cur.fsm == st_listen |-> cur.command == `CMD_TRANSCEIVE)
		else $error("transceive state without its command");

	a_send_to_listen: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_send && ext_event[`BIT_TX_END] && !wr_ctrl |=> cur.fsm == st_listen)
		else $error("send did not turn to listen");

	a_listen_stays: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_listen && !wr_ctrl |=> cur.fsm == st_listen)
		else $error("listening ended by itself");

	a_retain_pins: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_RETAIN |=> $stable(tx_active) && $stable(rx_enable))
		else $error("retain code moved the pins");

	a_echo_stays: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_echo && !wr_ctrl |=> tx_active && rx_enable)
		else $error("echo mode ended by itself");

	a_random_seed: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctrl && new_code == `CMD_RANDOM |=> cur.lfsr == `LFSR_SEED)
		else $error("random mode not reseeded");

	a_random_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm != st_random |-> !prbs_data)
		else $error("random data outside random mode");

	a_long_sequence: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_random && cur.seq_sel && !wr_ctrl |=>
		cur.lfsr[0] == $past(cur.lfsr[14] ^ cur.lfsr[13]))
		else $error("long sequence taps wrong");

	a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.wr_pend && cur.wr_idx == `IDX_ENABLE |=>
		cur.enable == $past(hwdata[`EN_RW_COUNT-1:0]))
		else $error("enable write lost");

	a_status_readonly: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.wr_pend && cur.wr_idx == `IDX_STATUS && ext_event == '0 |=> $stable(cur.status))
		else $error("status changed by a write");

	a_idle_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm != st_idle ##1 cur.fsm == st_idle |-> cur.status[`BIT_IDLE])
		else $error("idle entry not flagged");

	a_change_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(cur.fsm) |-> cur.status[`BIT_STATE_CHG])
		else $error("state change not flagged");

	a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_clear && hwdata[0] && ext_event[0] |=> cur.status[0])
		else $error("clear beat a new event");

	a_high_bits_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		hrdata[31:`FLAG_COUNT] == '0)
		else $error("unused read bits not zero");

	c_transceive: cover property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_send ##[1:20] cur.fsm == st_listen);
	c_random: cover property (@(posedge hclk) disable iff (!hresetn)
		cur.fsm == st_random && cur.seq_sel [*4]);
	c_irq_cleared: cover property (@(posedge hclk) disable iff (!hresetn)
		irq ##1 wr_clear ##1 !irq);
	c_set_beats_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		wr_clear && hwdata[0] && ext_event[0]);

endmodule

`default_nettype wire

// [rtl/irq_ctrl_defines.svh]
// Purpose: Constants for the contactless command and interrupt controller.
// Assumes: Register index times four gives the byte address on AHB-Lite.
// Notes: Behaviour list follows.
// Behaviour
// - Code 011 starts a transceive cycle
// - Transceive sends if initiator, else listens
// - Transceive never ends by itself
// - Code 100 keeps stored command unchanged
// - Code 101 sends and listens together
// - Code 110 sends random bits endlessly
// - Enable bits 16..0 gate flags, reset zero
// - Enable bits 19..17 read-only, fixed one
// - Timer flags at status bits 13..11
// - Card detect 19, fail 18, error 17, temperature 16
// - Subcarrier 15, frame start 14, tx 1, rx 0
// - Field fault 10, own on/off 9/8, external 7/6
// - State change 5, card 4, modulation 3, idle 2
// - Code 000 stops everything, returns idle
// - Sequence select: one 15-bit, zero 9-bit
// - Writing one to clear register clears flag
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL     4'h0
`define IDX_ENABLE      4'h1
`define IDX_STATUS      4'h2
`define IDX_CLEAR       4'h3

// Control register fields
`define CMD_LSB         0
`define CMD_MSB         2
`define START_SEND_BIT  3
`define SEQ_SEL_BIT     5
`define INITIATOR_BIT   7

// Command codes
`define CMD_HALT        3'h0
`define CMD_TRANSCEIVE  3'h3
`define CMD_RETAIN      3'h4
`define CMD_ECHO        3'h5
`define CMD_RANDOM      3'h6
`define CMD_RESET       3'h1

// Flag layout
`define FLAG_COUNT      20
`define EN_RW_COUNT     17
`define EN_FIXED        3'h7
`define BIT_STATE_CHG   5
`define BIT_IDLE        2
`define BIT_TX_END      1
`define BIT_RX_END      0

// Random sequence generator
`define LFSR_WIDTH      15
`define LFSR_SEED       15'h0001

`endif

// [rtl/irq_ctrl_pkg.sv]
// Purpose: Types shared by the command and interrupt controller.
// Assumes: Constants come from the defines header.
// Notes: All controller state is one packed struct.
`include "irq_ctrl_defines.svh"

package irq_ctrl_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_send,
		st_listen,
		st_echo,
		st_random
	} fsm_state_t;

	typedef struct packed {
		logic                     wr_pend;
		logic [3:0]               wr_idx;
		logic [31:0]              rdata;
		logic [2:0]               command;
		logic                     start_send;
		logic                     seq_sel;
		logic                     initiator;
		logic [`EN_RW_COUNT-1:0]  enable;
		logic [`FLAG_COUNT-1:0]   status;
		fsm_state_t               fsm;
		logic [`LFSR_WIDTH-1:0]   lfsr;
	} core_t;

endpackage

// [tb/ahb_host_model.sv]
// Purpose: AHB-Lite host model issuing single word transfers.
// Assumes: One slave whose hreadyout is the bus hready.
// Notes: Released write data is inverted so a stale word never looks valid.
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// Bus idle from time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Address phase held until hready, then data phase held until hready
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask
	// Flags drop when ones are written to the clear word
	task automatic clr(input logic [31:0] m);
		logic [31:0] q;
		xfer(1'b1, 32'hC, m, q);
	endtask
endmodule
`default_nettype wire

// [tb/contactless_cmd_irq_ctrl_bench.sv]
// Purpose: Self-checking bench for the command and interrupt controller.
// Assumes: Zero wait state slave; events are one-cycle pulses.
// Notes: Expectations come from the register layout, not from the design.
`include "irq_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module contactless_cmd_irq_ctrl_bench;
	import irq_ctrl_pkg::*;
	localparam logic [31:0] A_CTL = 32'h0, A_EN = 32'h4, A_ST = 32'h8;
	logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic                    tx_active, rx_enable, prbs_data, irq;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic [31:0]             haddr, hwdata, hrdata;
	logic [`FLAG_COUNT-1:0]  ext_event;
	int                      miscompares = 0, samples_checked = 0;
	contactless_cmd_irq_ctrl #(.DECODE_BITS(4)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_event(ext_event), .tx_active(tx_active),
		.rx_enable(rx_enable), .prbs_data(prbs_data), .irq(irq));
	ahb_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// Free running 8 ns clock
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [31:0] a, exp);
		logic [31:0] q;
		host_u.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// Settle one step so the write edge has landed before pins are looked at
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		host_u.xfer(1'b1, a, d, q);
		#1;
	endtask
	task automatic t_reset;
		rd_chk(A_EN, 32'h000E0000);
		rd_chk(A_ST, 32'h0);
		rd_chk(A_CTL, 32'h1);
		rd_chk(32'h30, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
	endtask
	task automatic t_enable;
		wr(A_EN, 32'hFFFFFFFF);
		rd_chk(A_EN, 32'h000FFFFF);
		wr(A_EN, 32'h0);
		rd_chk(A_EN, 32'h000E0000);
	endtask
	// Every flag position: set, hold, gate, clear
	task automatic t_events;
		for (int n = 0; n < 20; n++) begin
			@(posedge hclk);
			ext_event <= 20'h1 << n;
			@(posedge hclk);
			ext_event <= '0;
			repeat (4) @(posedge hclk);
			#1;
			chk({31'h0, irq}, {31'h0, n > 16});
			rd_chk(A_ST, 32'h1 << n);
			if (n < 17) begin
				wr(A_EN, 32'h1 << n);
				chk({31'h0, irq}, 32'h1);
			end
			host_u.clr(32'h1 << n);
			#1;
			chk({31'h0, irq}, 32'h0);
			rd_chk(A_ST, 32'h0);
			wr(A_EN, 32'h0);
		end
	endtask
	task automatic t_cmds;
		int toggles;
		logic last;
		toggles = 0;
		host_u.clr(32'hFFFFF);
		wr(A_CTL, 32'h83);
		chk({30'h0, tx_active, rx_enable}, 32'h2);
		repeat (50) @(posedge hclk);
		#1;
		chk({30'h0, tx_active, rx_enable}, 32'h2);
		wr(A_CTL, 32'h24);
		rd_chk(A_CTL, 32'h23);
		chk({30'h0, tx_active, rx_enable}, 32'h2);
		wr(A_CTL, 32'h0);
		chk({30'h0, tx_active, rx_enable}, 32'h0);
		rd_chk(A_ST, 32'h24);
		wr(A_CTL, 32'h83);
		@(posedge hclk);
		ext_event <= 20'h2;
		@(posedge hclk);
		ext_event <= '0;
		@(posedge hclk);
		#1;
		chk({30'h0, tx_active, rx_enable}, 32'h1);
		wr(A_CTL, 32'h03);
		chk({30'h0, tx_active, rx_enable}, 32'h1);
		wr(A_CTL, 32'h05);
		chk({30'h0, tx_active, rx_enable}, 32'h3);
		// Short then long sequence, each must keep toggling
		for (int k = 0; k < 2; k++) begin
			wr(A_CTL, (k == 0) ? 32'h06 : 32'h26);
			toggles = 0;
			last = prbs_data;
			repeat (60) begin
				@(posedge hclk);
				#1;
				toggles += (prbs_data !== last);
				last = prbs_data;
			end
			chk({30'h0, tx_active, toggles > 4}, 32'h3);
		end
		wr(A_CTL, 32'h0);
		chk({30'h0, tx_active, rx_enable}, 32'h0);
	endtask
	task automatic wrap_up;
		$display("checked=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Main sequence after an 8 cycle reset
	initial begin
		hresetn = 1'b0;
		ext_event = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_enable();
		t_events();
		t_cmds();
		wrap_up();
	end
	// Watchdog well beyond the roughly 650 cycles the tests need
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
